// File: hdl/timer_pwm_regs.svh
`ifndef TIMER_PWM_REGS_SVH
`define TIMER_PWM_REGS_SVH

// field positions inside timer_mode_reg
`define TMR_PWM_BIT 0
`define TMR_TOG_BIT 1
`define TMR_ALOAD_BIT 2
`define TMR_CKS_BIT 3
`define TMR_RATE_LSB 4
`define TMR_RATE_MSB 6
`define TMR_RUN_BIT 7

// counter boundaries for each modulus
`define TOP_256 8'hFF
`define TOP_64 8'h3F
`define TOP_32 8'h1F
`define TOP_16 8'h0F

// reset and step values
`define COUNT_ZERO 8'h00
`define COUNT_STEP 8'h01
`define RELOAD_RST 8'h00
`define PRESCALE_FULL 8'hFF
`define EXT_IDLE 1'b1

`endif

// File: hdl/timer_pwm_pkg.sv
package timer_pwm_pkg;

    typedef logic [7:0] count_t;
    typedef logic [2:0] rate_t;

    // modulus picked by {auto_reload_bit, toggle_out_enable} in pwm mode
    typedef enum logic [1:0] {
        MOD_256 = 2'b00,
        MOD_64 = 2'b01,
        MOD_32 = 2'b10,
        MOD_16 = 2'b11
    } pwm_range_t;

endpackage : timer_pwm_pkg

// File: hdl/timer_core_if.sv
`timescale 1ns/100ps

// signals shared by the counter core, the tick source and the comparator
interface timer_core_if;
    import timer_pwm_pkg::*;
    logic run;
    logic ext_select;
    rate_t rate;
    logic tick;
    logic pwm_mode;
    count_t count;
    count_t reference;
    count_t top;
    logic pwm_level;

    modport core (output run, ext_select, rate, pwm_mode, count, reference, top,
                  input tick, pwm_level);
    modport source (input run, ext_select, rate, output tick);
    modport compare (input run, pwm_mode, count, reference, top, output pwm_level);
endinterface : timer_core_if

// File: hdl/tick_source.sv
`timescale 1ns/100ps
`include "timer_pwm_regs.svh"

module tick_source
    import timer_pwm_pkg::*;
#(
    parameter int unsigned PRESCALE_W = 8
)
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ext_event_i,
    timer_core_if.source core
);

    logic [PRESCALE_W-1:0] prescale_r;
    logic ext_meta_r;
    logic ext_sync_r;
    logic ext_last_r;
    logic int_tick;
    logic ext_fall;

    // divisor 256 for code 000, halving each step down to 2 for 111
    function automatic logic [PRESCALE_W-1:0] rate_mask(input rate_t rate);
        rate_mask = {PRESCALE_W{1'b1}} >> rate;
    endfunction : rate_mask

    // free prescaler, held at zero while the timer is stopped
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prescale_r <= '0;
        end else if (!core.run) begin
            prescale_r <= '0;
        end else begin
            prescale_r <= prescale_r + 1'b1;
        end
    end

    // two-stage synchroniser and falling edge detect on the event pin
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ext_meta_r <= `EXT_IDLE;
            ext_sync_r <= `EXT_IDLE;
            ext_last_r <= `EXT_IDLE;
        end else begin
            ext_meta_r <= ext_event_i;
            ext_sync_r <= ext_meta_r;
            ext_last_r <= ext_sync_r;
        end
    end

    assign int_tick = (prescale_r & rate_mask(core.rate)) == rate_mask(core.rate);
    assign ext_fall = ext_last_r & ~ext_sync_r;
    // rate field has no effect with the event source selected
    assign core.tick = core.run & (core.ext_select ? ext_fall : int_tick);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_rate_div_two: assert property (
        core.run && !core.ext_select && core.rate == 3'h7 && core.tick
        |=> !core.tick ##1 (core.tick || !core.run || core.ext_select || core.rate != 3'h7))
        else $error("divide by two tick spacing wrong");
    a_event_only_edge: assert property (
        core.run && core.ext_select |-> core.tick == (ext_last_r && !ext_sync_r))
        else $error("event counter tick not from falling edge");

endmodule : tick_source

// File: hdl/pwm_compare.sv
`timescale 1ns/100ps

module pwm_compare
    import timer_pwm_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    timer_core_if.compare core
);

    count_t count_m;
    count_t ref_m;

    // values beyond the range are the caller's fault; only the in-range bits count
    assign count_m = core.count & core.top;
    assign ref_m = core.reference & core.top;

    // high below the reference, low from equality on; zero after wrap restarts high
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core.pwm_level <= 1'b0;
        end else begin
            core.pwm_level <= core.run & core.pwm_mode & (count_m < ref_m);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_low_at_equal: assert property (
        core.count == core.reference |=> !core.pwm_level)
        else $error("pwm not low at count equal reference");
    a_below_high: assert property (
        core.run && core.pwm_mode && count_m < ref_m |=> core.pwm_level)
        else $error("pwm not high while count below reference");

endmodule : pwm_compare

// File: hdl/timer_buzzer_pwm_output.sv
`timescale 1ns/100ps
`include "timer_pwm_regs.svh"

module timer_buzzer_pwm_output
    import timer_pwm_pkg::*;
#(
    parameter int unsigned PRESCALE_W = 8
)
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] timer_mode_reg_i,
    input wire logic timer_irq_enable_i,
    input wire logic count_wr_i,
    input wire logic [7:0] count_wdata_i,
    input wire logic reload_wr_i,
    input wire logic [7:0] reload_wdata_i,
    input wire logic irq_clr_i,
    input wire logic ext_event_i,
    output logic [7:0] timer_count_reg_o,
    output logic timer_irq_flag_o,
    output logic irq_o,
    output logic overflow_o,
    output logic shared_out_pin_o,
    output logic shared_out_oe_o
);

    timer_core_if core ();

    logic timer_run_bit;
    logic timer_clock_select;
    logic auto_reload_bit;
    logic toggle_out_enable;
    logic pwm_out_enable;
    pwm_range_t range;
    count_t top;
    logic reload_active;
    logic toggle_active;
    logic ovf;
    count_t count_r;
    count_t count_nxt;
    count_t reload_r;
    logic toggle_r;
    logic toggle_pin_r;
    logic irq_flag_r;
    logic oe_r;
    logic ovf_r;

    // boundary for each modulus code
    function automatic count_t range_top(input pwm_range_t r);
        case (r)
            MOD_256: range_top = `TOP_256;
            MOD_64: range_top = `TOP_64;
            MOD_32: range_top = `TOP_32;
            default: range_top = `TOP_16;
        endcase
    endfunction : range_top

    // mode field decode
    assign timer_run_bit = timer_mode_reg_i[`TMR_RUN_BIT];
    assign timer_clock_select = timer_mode_reg_i[`TMR_CKS_BIT];
    assign auto_reload_bit = timer_mode_reg_i[`TMR_ALOAD_BIT];
    assign toggle_out_enable = timer_mode_reg_i[`TMR_TOG_BIT];
    assign pwm_out_enable = timer_mode_reg_i[`TMR_PWM_BIT];
    assign range = pwm_range_t'({auto_reload_bit, toggle_out_enable});

    // counter boundary and reload control
    assign top = pwm_out_enable ? range_top(range) : `TOP_256;
    assign reload_active = auto_reload_bit | pwm_out_enable;
    // toggle bit only means buzzer while the pwm bit is clear
    assign toggle_active = toggle_out_enable & ~pwm_out_enable;
    assign ovf = core.tick & (count_r == top);

    // hookup to tick source and comparator
    assign core.run = timer_run_bit;
    assign core.ext_select = timer_clock_select;
    assign core.rate = timer_mode_reg_i[`TMR_RATE_MSB:`TMR_RATE_LSB];
    assign core.pwm_mode = pwm_out_enable;
    assign core.count = count_r;
    assign core.reference = reload_r;
    assign core.top = top;

    tick_source #(
        .PRESCALE_W(PRESCALE_W)
    ) u_tick (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ext_event_i(ext_event_i),
        .core(core)
    );

    pwm_compare u_cmp (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .core(core)
    );

    // next count: software write first, then tick step or overflow load
    always_comb begin
        count_nxt = count_r;
        if (count_wr_i) begin
            count_nxt = count_wdata_i;
        end else if (ovf) begin
            if (pwm_out_enable) begin
                count_nxt = `COUNT_ZERO;
            end else if (reload_active) begin
                count_nxt = reload_r;
            end else begin
                count_nxt = `COUNT_ZERO;
            end
        end else if (core.tick) begin
            count_nxt = count_r + `COUNT_STEP;
        end
    end

    // counter register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_r <= `COUNT_ZERO;
        end else begin
            count_r <= count_nxt;
        end
    end

    // reference has no read path and acts at once on the compare
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reload_r <= `RELOAD_RST;
        end else if (reload_wr_i) begin
            reload_r <= reload_wdata_i;
        end
    end

    // buzzer toggle flips on every overflow while toggle_active, held low otherwise
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            toggle_r <= 1'b0;
        end else if (!toggle_active) begin
            toggle_r <= 1'b0;
        end else if (ovf) begin
            toggle_r <= ~toggle_r;
        end
    end

    // buzzer pin level, held low while stopped
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            toggle_pin_r <= 1'b0;
        end else begin
            toggle_pin_r <= timer_run_bit & toggle_active & toggle_r;
        end
    end

    // sticky overflow flag, a new overflow beats the clear
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_flag_r <= 1'b0;
        end else if (ovf) begin
            irq_flag_r <= 1'b1;
        end else if (irq_clr_i) begin
            irq_flag_r <= 1'b0;
        end
    end

    // pin ownership and overflow strobe
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            oe_r <= 1'b0;
            ovf_r <= 1'b0;
        end else begin
            oe_r <= pwm_out_enable | toggle_active;
            ovf_r <= ovf;
        end
    end

    // outputs
    assign timer_count_reg_o = count_r;
    assign timer_irq_flag_o = irq_flag_r;
    assign irq_o = irq_flag_r & timer_irq_enable_i;
    assign overflow_o = ovf_r;
    assign shared_out_pin_o = pwm_out_enable ? core.pwm_level : toggle_pin_r;
    assign shared_out_oe_o = oe_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_wrap_in_pwm;
        timer_run_bit && pwm_out_enable && ovf && !count_wr_i && !reload_wr_i
            && (reload_r & top) != `COUNT_ZERO;
    endsequence

    sequence s_stay_pwm;
        timer_run_bit && pwm_out_enable && !count_wr_i;
    endsequence

    a_toggle_on_ovf: assert property (
        ovf && toggle_active && $past(toggle_active) |=> toggle_r != $past(toggle_r))
        else $error("buzzer did not toggle on overflow");
    a_pin_owned: assert property (
        (toggle_active || pwm_out_enable) ##1 (toggle_active || pwm_out_enable)
        |-> shared_out_oe_o)
        else $error("pin not driven while output enabled");
    a_stop_outputs: assert property (
        !timer_run_bit ##1 !timer_run_bit |-> !shared_out_pin_o && !core.tick)
        else $error("output active while timer stopped");
    a_mod_sixteen: assert property (
        ovf && pwm_out_enable && range == MOD_16 |-> count_r == `TOP_16)
        else $error("modulus sixteen boundary wrong");
    a_wrap_high: assert property (
        s_wrap_in_pwm ##1 s_stay_pwm |=> core.pwm_level)
        else $error("pwm not high after wrap");
    a_count_write: assert property (
        count_wr_i |=> count_r == $past(count_wdata_i))
        else $error("counter write lost");
    a_irq_on_ovf: assert property (
        ovf |=> timer_irq_flag_o ##1 (timer_irq_flag_o || $past(irq_clr_i)))
        else $error("overflow did not set flag");
    a_flag_sticky: assert property (
        timer_irq_flag_o && !irq_clr_i |=> timer_irq_flag_o)
        else $error("interrupt flag dropped without clear");
    a_reload_copy: assert property (
        ovf && !pwm_out_enable && auto_reload_bit && !count_wr_i
        |=> count_r == $past(reload_r))
        else $error("reference not reloaded on overflow");
    a_count_step: assert property (
        core.tick && !ovf && !count_wr_i |=> count_r == $past(count_r) + `COUNT_STEP)
        else $error("counter did not step on tick");
    a_pwm_reload_forced: assert property (
        ovf && pwm_out_enable && !count_wr_i |=> count_r == `COUNT_ZERO)
        else $error("pwm period did not restart at zero");

    sequence s_buzzer_run;
        timer_run_bit && toggle_active;
    endsequence

    sequence s_pin_free;
        !toggle_active && !pwm_out_enable;
    endsequence

    // buzzer level reaches the pin one clock after the toggle register
    a_buzzer_on_pin: assert property (
        s_buzzer_run ##1 !pwm_out_enable |-> shared_out_pin_o == $past(toggle_r))
        else $error("buzzer level not on pin");
    // toggle register rests low while the buzzer is off
    a_toggle_idle: assert property (
        !toggle_active |=> !toggle_r)
        else $error("buzzer toggle not cleared");
    // pin handed back to general I/O once both outputs are off
    a_pin_released: assert property (
        s_pin_free ##1 s_pin_free |-> !shared_out_oe_o)
        else $error("pin still driven with outputs off");
    // a stopped counter only changes by a software write
    a_count_frozen: assert property (
        !timer_run_bit && !count_wr_i |=> count_r == $past(count_r))
        else $error("counter moved while stopped");
    // compare level drops one clock after the run bit clears
    a_pwm_stopped: assert property (
        !timer_run_bit |=> !core.pwm_level)
        else $error("pwm level high while stopped");
    // plain timer overflows only at the full boundary
    a_plain_top: assert property (
        ovf && !pwm_out_enable |-> count_r == `TOP_256)
        else $error("plain timer boundary wrong");
    // overflow strobe is the overflow tick, one clock late
    a_ovf_strobe: assert property (
        ovf |=> overflow_o)
        else $error("overflow strobe missing");
    a_ovf_single: assert property (
        overflow_o |-> $past(ovf))
        else $error("overflow strobe without overflow");
    // pwm level on the pin matches the masked compare of the clock before
    a_pwm_on_pin: assert property (
        s_stay_pwm ##1 pwm_out_enable |-> shared_out_pin_o ==
            (($past(count_r) & $past(top)) < ($past(reload_r) & $past(top))))
        else $error("pwm level not on pin");
    // pwm overflows still raise the interrupt flag
    a_pwm_irq: assert property (
        ovf && pwm_out_enable |=> timer_irq_flag_o)
        else $error("pwm overflow lost interrupt flag");
    // reference changes only through a write
    a_reload_hold: assert property (
        !reload_wr_i |=> reload_r == $past(reload_r))
        else $error("reference changed without write");
    // clear without an overflow empties the flag
    a_flag_clear: assert property (
        irq_clr_i && !ovf |=> !timer_irq_flag_o)
        else $error("interrupt flag not cleared");

endmodule : timer_buzzer_pwm_output

// File: bench/pin_load_model.sv
`timescale 1ns/100ps

// load on the shared pin; pulled low whenever the block lets go of it
module pin_load_model (
    input wire logic clk_i,
    input wire logic clear_i,
    input wire logic pin_i,
    input wire logic oe_i,
    output logic [15:0] high_cnt_o,
    output logic [15:0] rise_cnt_o
);
    logic level;
    logic last_r;

    // the load only sees the pin while the block owns it
    assign level = oe_i ? pin_i : 1'b0;

    // count high cycles and rising edges seen by the load
    always_ff @(posedge clk_i) begin
        last_r <= level;
        high_cnt_o <= clear_i ? 16'h0000 : high_cnt_o + 16'(level);
        rise_cnt_o <= clear_i ? 16'h0000 : rise_cnt_o + 16'(level & ~last_r);
    end
endmodule : pin_load_model

// File: bench/timer_buzzer_pwm_output_bench.sv
`timescale 1ns/100ps

module timer_buzzer_pwm_output_bench;
    import timer_pwm_pkg::*;
    typedef struct {int s; logic [15:0] v;} note_t;
    logic clk, rst_n, irq_en, cwr, rwr, iclr, ext, clr;
    logic [7:0] mode, cdat, rdat, cnt;
    logic flag, irq, ovf, pin, oe;
    logic [15:0] hi, ri, ovf_cnt, obs;
    note_t q[$];
    note_t n;
    int fail_count = 0;
    int comparisons = 0;
    int m_len;
    logic [7:0] r8;
    string nm[8] = '{"count", "flag", "irq", "pin", "oe", "high", "rises", "ovfs"};

    timer_buzzer_pwm_output #(.PRESCALE_W(8)) DUT (.clk_i(clk), .reset_n_i(rst_n),
        .timer_mode_reg_i(mode), .timer_irq_enable_i(irq_en), .count_wr_i(cwr),
        .count_wdata_i(cdat), .reload_wr_i(rwr), .reload_wdata_i(rdat),
        .irq_clr_i(iclr), .ext_event_i(ext), .timer_count_reg_o(cnt),
        .timer_irq_flag_o(flag), .irq_o(irq), .overflow_o(ovf),
        .shared_out_pin_o(pin), .shared_out_oe_o(oe));
    pin_load_model load (.clk_i(clk), .clear_i(clr), .pin_i(pin), .oe_i(oe),
        .high_cnt_o(hi), .rise_cnt_o(ri));

    // clock at 50 MHz
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // overflow pulses counted over a measuring window
    always @(posedge clk) ovf_cnt <= clr ? 16'h0000 : ovf_cnt + 16'(ovf);

    // monitor: takes the oldest note and compares it with what is seen now
    initial forever begin
        wait (q.size() != 0);
        n = q.pop_front();
        case (n.s)
            0: obs = 16'(cnt);
            1: obs = 16'(flag);
            2: obs = 16'(irq);
            3: obs = 16'(pin);
            4: obs = 16'(oe);
            5: obs = hi;
            6: obs = ri;
            default: obs = ovf_cnt;
        endcase
        comparisons++;
        if (obs !== n.v) begin
            $display("mismatch %s exp %0h seen %0h", nm[n.s], n.v, obs);
            fail_count++;
        end
    end

    task tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick

    task chk(input int s, input logic [15:0] v);
        q.push_back('{s, v});
    endtask : chk

    task wr_cnt(input logic [7:0] d);
        cwr = 1'b1;
        cdat = d;
        tick(1);
        cwr = 1'b0;
    endtask : wr_cnt

    task wr_ref(input logic [7:0] d);
        rwr = 1'b1;
        rdat = d;
        tick(1);
        rwr = 1'b0;
    endtask : wr_ref

    task win(input int k);
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        tick(k);
    endtask : win

    task test_done;
        tick(1);
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    task wait_ovf;
        int k;
        k = 0;
        while (ovf !== 1'b1 && k < 600) begin
            tick(1);
            k++;
        end
        if (ovf !== 1'b1) begin
            $display("mismatch overflow exp 1 seen 0");
            fail_count++;
            test_done;
        end
    endtask : wait_ovf

    // main sequence
    initial begin
        rst_n = 1'b0;
        mode = 8'h00;
        irq_en = 1'b0;
        cwr = 1'b0;
        cdat = 8'h00;
        rwr = 1'b0;
        rdat = 8'h00;
        iclr = 1'b0;
        ext = 1'b1;
        clr = 1'b0;
        void'($urandom(32'h5AE8));
        tick(3);
        rst_n = 1'b1;
        chk(0, 16'h0000);
        chk(1, 16'h0000);
        chk(3, 16'h0000);
        chk(4, 16'h0000);
        tick(1);
        $display("test reset done");
        // every rate code: four ticks take four divisor periods
        for (int r = 0; r < 8; r++) begin
            mode = {1'b1, 3'(r), 4'h0};
            tick((256 >> r) * 2);
            wr_cnt(8'h00);
            tick((256 >> r) * 4);
            chk(0, 16'h0004);
        end
        $display("test rates done");
        // buzzer with auto reload, pwm bit kept clear
        mode = 8'h76;
        wr_ref(8'hFC);
        wr_cnt(8'hFC);
        irq_en = 1'b1;
        mode = 8'hF6;
        wait_ovf;
        chk(0, 16'h00FC);
        chk(1, 16'h0001);
        chk(2, 16'h0001);
        chk(4, 16'h0001);
        win(64);
        chk(6, 16'h0004);
        chk(7, 16'h0008);
        $display("test buzzer done");
        // stop, then sticky flag and its enable
        mode = 8'h76;
        tick(2);
        wr_cnt(8'h05);
        win(20);
        chk(0, 16'h0005);
        chk(7, 16'h0000);
        chk(3, 16'h0000);
        chk(1, 16'h0001);
        irq_en = 1'b0;
        tick(1);
        chk(2, 16'h0000);
        tick(1);
        irq_en = 1'b1;
        iclr = 1'b1;
        tick(1);
        iclr = 1'b0;
        chk(1, 16'h0000);
        chk(2, 16'h0000);
        tick(1);
        $display("test stop done");
        // pwm in every range with a random duty inside it
        for (int m = 0; m < 4; m++) begin
            m_len = (m == 0) ? 256 : (128 >> m);
            r8 = 8'($urandom_range(m_len - 1));
            mode = {1'b0, 3'b111, 1'b0, 2'(m), 1'b1};
            wr_ref(r8);
            wr_cnt(8'h00);
            mode[7] = 1'b1;
            tick(4 * m_len);
            win(4 * m_len);
            chk(5, 16'(r8) * 16'h0004);
            chk(7, 16'h0002);
            chk(4, 16'h0001);
            chk(2, 16'h0001);
        end
        $display("test pwm done");
        // counter write acts on the compare at once
        mode = 8'h81;
        wr_ref(8'h80);
        wr_cnt(8'h90);
        tick(2);
        chk(3, 16'h0000);
        wr_cnt(8'h10);
        tick(2);
        chk(3, 16'h0001);
        tick(1);
        $display("test count write done");
        // event source counts falling edges, rate ignored
        mode = 8'hF8;
        wr_cnt(8'h10);
        repeat (5) begin
            ext = 1'b0;
            tick(4);
            ext = 1'b1;
            tick(4);
        end
        tick(4);
        chk(0, 16'h0015);
        $display("test events done");
        test_done;
    end
endmodule : timer_buzzer_pwm_output_bench
